//--- logic/dsd_pkg.sv
// Constants and types shared by the data-space decoder and the non-volatile data port
package dsd_pkg;
	// ==========================================================
	// Data space map
	localparam logic [15:0] DSD_REGS_BASE = 16'h0000;
	localparam logic [15:0] DSD_IO_BASE = 16'h0020;
	localparam logic [15:0] DSD_EXT_BASE = 16'h0060;
	localparam logic [15:0] DSD_SRAM_BASE = 16'h0100;
	localparam logic [15:0] DSD_SRAM_TOP_SMALL = 16'h02FF;
	localparam logic [15:0] DSD_SRAM_TOP_LARGE = 16'h04FF;
	localparam int DSD_SRAM_BYTES_SMALL = 512;
	localparam int DSD_SRAM_BYTES_LARGE = 1024;
	localparam int DSD_IO_COUNT = 64;
	localparam logic [5:0] DSD_DISP_MAX = 6'h3F;
	// Pointer pair indices in the register file
	localparam logic [4:0] DSD_PTR_X_LO = 5'h1A;
	localparam logic [4:0] DSD_PTR_Y_LO = 5'h1C;
	localparam logic [4:0] DSD_PTR_Z_LO = 5'h1E;
	// ==========================================================
	// Non-volatile port register offsets in I/O space
	localparam logic [5:0] DSD_IO_NVM_CTRL = 6'h1F;
	localparam logic [5:0] DSD_IO_NVM_DATA = 6'h20;
	localparam logic [5:0] DSD_IO_NVM_PTR_LO = 6'h21;
	localparam logic [5:0] DSD_IO_NVM_PTR_HI = 6'h22;
	// Control register field positions
	localparam int DSD_CTL_READ = 0;
	localparam int DSD_CTL_WRITE = 1;
	localparam int DSD_CTL_ARM = 2;
	localparam int DSD_CTL_MODE_LO = 4;
	localparam int DSD_CTL_MODE_HI = 5;
	localparam logic [1:0] DSD_MODE_RESET = 2'h0;
	// ==========================================================
	// Timing
	localparam int DSD_CLK_HZ = 10_000_000;
	localparam int DSD_ARM_CYCLES = 4;
	localparam int DSD_READ_STALL = 4;
	localparam int DSD_WRITE_STALL = 2;
	localparam int DSD_SRAM_CYCLES = 2;
	localparam int DSD_T_ATOMIC_US = 3400;
	localparam int DSD_T_SPLIT_US = 1800;
	localparam int DSD_ATOMIC_CYC = DSD_T_ATOMIC_US * (DSD_CLK_HZ / 1_000_000);
	localparam int DSD_SPLIT_CYC = DSD_T_SPLIT_US * (DSD_CLK_HZ / 1_000_000);

	typedef enum logic [1:0] {
		DSD_PM_ATOMIC,
		DSD_PM_ERASE,
		DSD_PM_WRITE,
		DSD_PM_RSVD
	} dsd_pmode_t;

	typedef enum logic [2:0] {
		DSD_RG_REGS,
		DSD_RG_IO,
		DSD_RG_EXT,
		DSD_RG_SRAM,
		DSD_RG_NONE
	} dsd_region_t;

	typedef enum logic [2:0] {
		DSD_AM_DIRECT,
		DSD_AM_DISP,
		DSD_AM_IND,
		DSD_AM_PREDEC,
		DSD_AM_POSTINC,
		DSD_AM_IO
	} dsd_amode_t;
endpackage

//--- logic/dsd_decode.sv
// Data space region decoder: one region and local offset per address
module dsd_decode #(
	parameter int SRAM_BYTES = 1024
) (
	input wire logic [15:0] addr, // Linear data address
	output dsd_pkg::dsd_region_t region, // Selected region
	output logic [15:0] offset // Address within the region
);
	import dsd_pkg::*;
	localparam logic [15:0] TOP = (SRAM_BYTES == DSD_SRAM_BYTES_SMALL) ?
		DSD_SRAM_TOP_SMALL : DSD_SRAM_TOP_LARGE;

	initial begin
		if (SRAM_BYTES != DSD_SRAM_BYTES_SMALL && SRAM_BYTES != DSD_SRAM_BYTES_LARGE)
			$error("dsd_decode: SRAM_BYTES must be 512 or 1024");
	end

	// Priority order keeps exactly one region per address
	always_comb begin
		if (addr < DSD_IO_BASE) begin
			region = DSD_RG_REGS;
			offset = addr - DSD_REGS_BASE;
		end else if (addr < DSD_EXT_BASE) begin
			region = DSD_RG_IO;
			offset = addr - DSD_IO_BASE;
		end else if (addr < DSD_SRAM_BASE) begin
			region = DSD_RG_EXT;
			offset = addr - DSD_EXT_BASE;
		end else if (addr <= TOP) begin
			region = DSD_RG_SRAM;
			offset = addr - DSD_SRAM_BASE;
		end else begin
			region = DSD_RG_NONE;
			offset = 16'h0000;
		end
	end
endmodule

//--- logic/dsd_memsys.sv
// Memory subsystem: data space decode, pointer updates, SRAM and non-volatile data port
module dsd_memsys
	import dsd_pkg::*;
#(
	parameter int SRAM_BYTES = 1024,
	parameter int NVM_BYTES = 512,
	parameter int PROG_WORDS = 8192,
	parameter int ATOMIC_CYC = DSD_ATOMIC_CYC,
	parameter int SPLIT_CYC = DSD_SPLIT_CYC
) (
	input wire logic clk, // Processor clock
	input wire logic nrst, // Asynchronous reset, active low
	input wire logic acc_req, // Access request, one cycle
	input wire logic acc_we, // Store when high, load when low
	input wire dsd_pkg::dsd_amode_t acc_mode, // Addressing mode
	input wire logic [15:0] acc_addr, // Direct address, or I/O index in IO mode
	input wire logic [1:0] acc_ptr, // Pointer: 0 X, 1 Y, 2 Z
	input wire logic [5:0] acc_disp, // Displacement
	input wire logic [7:0] acc_wdata, // Store data
	output logic [7:0] acc_rdata, // Load data
	output logic acc_done, // Access complete, one cycle
	output logic acc_err, // Refused access, one cycle
	output logic cpu_stall, // Processor must hold
	input wire logic [$clog2(PROG_WORDS)-1:0] pc_next, // Next program counter
	input wire logic pc_load, // Load program counter
	output logic [$clog2(PROG_WORDS)-1:0] pc, // Program counter
	output logic [15:0] prog_addr, // Program word address
	input wire logic [15:0] prog_word, // Program word read
	output logic [15:0] instr_r, // Latched instruction word
	output logic nvm_busy // Self-timed programming in progress
);
	import dsd_pkg::*;
	localparam int PCW = $clog2(PROG_WORDS);
	localparam int NAW = $clog2(NVM_BYTES);
	localparam int SAW = $clog2(SRAM_BYTES);

	initial begin
		if (NVM_BYTES != 256 && NVM_BYTES != 512)
			$error("dsd_memsys: NVM_BYTES must be 256 or 512");
		if (PROG_WORDS != 2048 && PROG_WORDS != 4096 && PROG_WORDS != 8192)
			$error("dsd_memsys: PROG_WORDS must be 2048, 4096 or 8192");
	end
	// ==========================================================
	// Reset release
	logic rst_s1_r, rst_n;
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_r <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_n <= rst_s1_r;
		end
	end
	// ==========================================================
	// Storage
	logic [7:0] regs_r [32];
	logic [7:0] ext_r [160];
	logic [7:0] sram_r [SRAM_BYTES];
	logic [7:0] nvm_r [NVM_BYTES];
	// ==========================================================
	// Program counter and program word
	logic [PCW-1:0] pc_nxt;
	logic [15:0] instr_nxt;
	always_comb begin
		pc_nxt = pc_load ? pc_next : pc;
		instr_nxt = cpu_stall ? instr_r : prog_word;
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc <= '0;
			instr_r <= 16'h0000;
		end else begin
			pc <= pc_nxt;
			instr_r <= instr_nxt;
		end
	end
	assign prog_addr = 16'(pc);
	// ==========================================================
	// Effective address
	logic [15:0] ptr_val, eff_addr, ptr_new;
	logic [4:0] ptr_idx;
	dsd_region_t region;
	logic [15:0] roff;
	always_comb begin
		case (acc_ptr)
			2'h1: ptr_idx = DSD_PTR_Y_LO;
			2'h2: ptr_idx = DSD_PTR_Z_LO;
			default: ptr_idx = DSD_PTR_X_LO;
		endcase
		ptr_val = {regs_r[ptr_idx + 5'h01], regs_r[ptr_idx]};
		ptr_new = ptr_val;
		case (acc_mode)
			DSD_AM_DIRECT: eff_addr = acc_addr;
			DSD_AM_DISP: eff_addr = ptr_val + {10'h000, acc_disp & DSD_DISP_MAX};
			DSD_AM_IND: eff_addr = ptr_val;
			DSD_AM_PREDEC: begin
				ptr_new = ptr_val - 16'h0001;
				eff_addr = ptr_new;
			end
			DSD_AM_POSTINC: begin
				ptr_new = ptr_val + 16'h0001;
				eff_addr = ptr_val;
			end
			DSD_AM_IO: eff_addr = DSD_IO_BASE + {10'h000, acc_addr[5:0]};
			default: eff_addr = acc_addr;
		endcase
	end

	dsd_decode #(.SRAM_BYTES(SRAM_BYTES)) u_dec (
		.addr(eff_addr),
		.region(region),
		.offset(roff)
	);
	// Short I/O forms carry a 6-bit index, so extended I/O cannot be named
	logic io_bad, disp_bad;
	assign io_bad = (acc_mode == DSD_AM_IO) && (acc_addr >= 16'(DSD_IO_COUNT));
	assign disp_bad = (acc_mode == DSD_AM_DISP) && (acc_ptr == 2'h0);
	// ==========================================================
	// Non-volatile port registers
	logic [NAW-1:0] nptr_r, nptr_nxt;
	logic [7:0] ndata_r, ndata_nxt;
	logic [1:0] nmode_r, nmode_nxt;
	logic arm_r, arm_nxt, wstb_r, wstb_nxt;
	logic [2:0] arm_cnt_r, arm_cnt_nxt;
	logic [31:0] prog_cnt_r, prog_cnt_nxt;
	logic [2:0] stall_r, stall_nxt;
	dsd_pmode_t op_r, op_nxt;
	// ==========================================================
	// Access sequencing: SRAM takes a second cycle
	logic sram_ph_r, sram_ph_nxt;
	// Latched SRAM offset and data for the second cycle
	logic [15:0] roff_q;
	logic we_q;
	logic [7:0] wd_q;
	logic [7:0] rdata_nxt;
	logic done_nxt, err_nxt;
	logic go, io_wr;
	logic [5:0] io_idx;
	logic [7:0] io_rd;

	always_comb begin
		go = acc_req && !cpu_stall && !sram_ph_r;
		io_idx = roff[5:0];
		io_wr = go && acc_we && !io_bad && !disp_bad && region == DSD_RG_IO;
		case (io_idx)
			DSD_IO_NVM_CTRL: io_rd = {2'h0, nmode_r, 1'b0, arm_r, wstb_r, 1'b0};
			DSD_IO_NVM_DATA: io_rd = ndata_r;
			DSD_IO_NVM_PTR_LO: io_rd = 8'(nptr_r);
			DSD_IO_NVM_PTR_HI: io_rd = 8'(16'(nptr_r) >> 8);
			default: io_rd = 8'h00;
		endcase
	end

	logic sram_go;
	always_comb begin
		sram_go = go && !io_bad && !disp_bad && region == DSD_RG_SRAM;
		sram_ph_nxt = sram_go;
		done_nxt = 1'b0;
		err_nxt = 1'b0;
		rdata_nxt = acc_rdata;
		if (sram_ph_r) begin
			done_nxt = 1'b1;
			rdata_nxt = sram_r[roff_q[SAW-1:0]];
		end else if (go) begin
			if (io_bad || disp_bad || region == DSD_RG_NONE) begin
				err_nxt = 1'b1;
			end else if (region != DSD_RG_SRAM) begin
				done_nxt = 1'b1;
				case (region)
					DSD_RG_REGS: rdata_nxt = regs_r[roff[4:0]];
					DSD_RG_IO: rdata_nxt = io_rd;
					default: rdata_nxt = ext_r[roff[7:0]];
				endcase
			end
		end
	end
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sram_ph_r <= 1'b0;
			acc_done <= 1'b0;
			acc_err <= 1'b0;
			acc_rdata <= 8'h00;
			roff_q <= 16'h0000;
			we_q <= 1'b0;
			wd_q <= 8'h00;
		end else begin
			sram_ph_r <= sram_ph_nxt;
			acc_done <= done_nxt;
			acc_err <= err_nxt;
			acc_rdata <= rdata_nxt;
			if (sram_go) begin
				roff_q <= roff;
				we_q <= acc_we;
				wd_q <= acc_wdata;
			end
		end
	end
	// Memories carry no reset; contents start undefined like real storage
	always_ff @(posedge clk) begin
		if (sram_ph_r && we_q)
			sram_r[roff_q[SAW-1:0]] <= wd_q;
		if (go && acc_we && !io_bad && !disp_bad && region == DSD_RG_EXT)
			ext_r[roff[7:0]] <= acc_wdata;
	end
	// Register file: a store wins over the pointer update only if it hits the pointer itself
	logic ptr_upd;
	assign ptr_upd = go && !io_bad && !disp_bad && region != DSD_RG_NONE &&
		(acc_mode == DSD_AM_PREDEC || acc_mode == DSD_AM_POSTINC);
	always_ff @(posedge clk) begin
		if (ptr_upd) begin
			regs_r[ptr_idx] <= ptr_new[7:0];
			regs_r[ptr_idx + 5'h01] <= ptr_new[15:8];
		end
		if (go && acc_we && !io_bad && !disp_bad && region == DSD_RG_REGS)
			regs_r[roff[4:0]] <= acc_wdata;
	end
	// ==========================================================
	// Non-volatile control
	logic ctl_wr, rd_trig, wr_trig;
	logic [7:0] wv;
	always_comb begin
		wv = acc_wdata;
		ctl_wr = io_wr && io_idx == DSD_IO_NVM_CTRL;
		rd_trig = ctl_wr && wv[DSD_CTL_READ] && !wstb_r;
		wr_trig = ctl_wr && wv[DSD_CTL_WRITE] && arm_r && !wstb_r;
		nptr_nxt = nptr_r;
		ndata_nxt = ndata_r;
		nmode_nxt = nmode_r;
		arm_nxt = arm_r;
		arm_cnt_nxt = arm_cnt_r;
		wstb_nxt = wstb_r;
		prog_cnt_nxt = prog_cnt_r;
		stall_nxt = (stall_r != 3'h0) ? stall_r - 3'h1 : 3'h0;
		op_nxt = op_r;
		if (io_wr && io_idx == DSD_IO_NVM_PTR_LO && !wstb_r)
			nptr_nxt = NAW'({16'(nptr_r) >> 8, wv});
		if (io_wr && io_idx == DSD_IO_NVM_PTR_HI && !wstb_r && NAW > 8)
			nptr_nxt = NAW'({wv[0], nptr_r[7:0]});
		if (io_wr && io_idx == DSD_IO_NVM_DATA)
			ndata_nxt = wv;
		if (arm_r) begin
			arm_cnt_nxt = arm_cnt_r - 3'h1;
			if (arm_cnt_r == 3'h1)
				arm_nxt = 1'b0;
		end
		if (ctl_wr) begin
			if (!wstb_r)
				nmode_nxt = {wv[DSD_CTL_MODE_HI], wv[DSD_CTL_MODE_LO]};
			if (wv[DSD_CTL_ARM] && !wv[DSD_CTL_WRITE]) begin
				arm_nxt = 1'b1;
				arm_cnt_nxt = 3'(DSD_ARM_CYCLES);
			end
		end
		if (rd_trig) begin
			ndata_nxt = nvm_r[nptr_r];
			stall_nxt = 3'(DSD_READ_STALL);
		end
		if (wstb_r) begin
			prog_cnt_nxt = prog_cnt_r - 32'h1;
			if (prog_cnt_r == 32'h1)
				wstb_nxt = 1'b0;
		end
		if (wr_trig) begin
			wstb_nxt = 1'b1;
			arm_nxt = 1'b0;
			op_nxt = dsd_pmode_t'(nmode_r);
			prog_cnt_nxt = (nmode_r == DSD_PM_ATOMIC) ? 32'(ATOMIC_CYC) : 32'(SPLIT_CYC);
			stall_nxt = 3'(DSD_WRITE_STALL);
			if (nmode_r == DSD_PM_RSVD)
				wstb_nxt = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			nptr_r <= '0;
			ndata_r <= 8'h00;
			nmode_r <= DSD_MODE_RESET;
			arm_r <= 1'b0;
			arm_cnt_r <= 3'h0;
			wstb_r <= 1'b0;
			prog_cnt_r <= 32'h0;
			stall_r <= 3'h0;
			op_r <= DSD_PM_ATOMIC;
		end else begin
			nptr_r <= nptr_nxt;
			ndata_r <= ndata_nxt;
			nmode_r <= nmode_nxt;
			arm_r <= arm_nxt;
			arm_cnt_r <= arm_cnt_nxt;
			wstb_r <= wstb_nxt;
			prog_cnt_r <= prog_cnt_nxt;
			stall_r <= stall_nxt;
			op_r <= op_nxt;
		end
	end

	// Array is committed at completion so a reset mid-write leaves old content
	always_ff @(posedge clk) begin
		if (wstb_r && prog_cnt_r == 32'h1) begin
			case (op_r)
				DSD_PM_ERASE: nvm_r[nptr_r] <= 8'hFF;
				DSD_PM_WRITE: nvm_r[nptr_r] <= nvm_r[nptr_r] & ndata_r;
				default: nvm_r[nptr_r] <= ndata_r;
			endcase
		end
	end

	assign cpu_stall = (stall_r != 3'h0) || sram_ph_r;
	assign nvm_busy = wstb_r;
endmodule

//--- tb/dsd_prog_rom.sv
// Program memory model answering word fetches
module dsd_prog_rom (
	input wire logic [15:0] prog_addr, // Word address
	output logic [15:0] prog_word // Fetched word
);
	timeunit 1ns;
	timeprecision 1ns;
	// Word tracks its address so a misdirected fetch is visible
	assign prog_word = prog_addr ^ 16'hA5C3;
endmodule

//--- tb/dsd_memsys_chk.sv
// Port checker of the memory subsystem
module dsd_memsys_chk #(
	parameter int SRAM_BYTES = 1024,
	parameter int PROG_WORDS = 8192,
	parameter int ATOMIC_CYC = 20,
	parameter int SPLIT_CYC = 10
) (
	input wire logic clk, // Clock
	input wire logic nrst, // Reset, active low
	input wire logic acc_req, // Request
	input wire logic acc_we, // Store
	input wire dsd_pkg::dsd_amode_t acc_mode, // Mode
	input wire logic [15:0] acc_addr, // Address
	input wire logic [1:0] acc_ptr, // Pointer
	input wire logic [7:0] acc_wdata, // Store data
	input wire logic acc_done, // Done
	input wire logic acc_err, // Refused
	input wire logic cpu_stall, // Stall
	input wire logic [$clog2(PROG_WORDS)-1:0] pc, // Program counter
	input wire logic [15:0] prog_addr, // Program address
	input wire logic nvm_busy // Programming
);
	timeunit 1ns;
	timeprecision 1ns;
	import dsd_pkg::*;
	// ==========================================================
	// Helper logic
	logic [15:0] busy_cnt_r;
	logic [15:0] busy_cnt_nxt;
	logic take;
	logic dir;
	logic [15:0] top;
	assign take = acc_req && !cpu_stall;
	assign dir = take && acc_mode == DSD_AM_DIRECT;
	assign top = 16'(32'(DSD_SRAM_BASE) + SRAM_BYTES - 1);
	always_comb begin
		busy_cnt_nxt = nvm_busy ? busy_cnt_r + 16'h0001 : 16'h0000;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			busy_cnt_r <= 16'h0000;
		end else begin
			busy_cnt_r <= busy_cnt_nxt;
		end
	end
	// ==========================================================
	// Assertions
	default clocking dc @(posedge clk);
	endclocking
	default disable iff (!nrst);
	a_answer_exclusive: assert property (!(acc_done && acc_err))
		else $error("done and error together");
	a_sram_two_cycles: assert property (dir && acc_addr >= DSD_SRAM_BASE
		&& acc_addr <= top |-> ##1 (cpu_stall && !acc_done) ##1 acc_done)
		else $error("sram access not two cycles");
	a_low_one_cycle: assert property (dir && acc_addr < DSD_SRAM_BASE
		|-> ##1 acc_done) else $error("low region access late");
	a_unmapped_err: assert property (dir && acc_addr > top |=> acc_err)
		else $error("unmapped address accepted");
	a_io_range_err: assert property (take && acc_mode == DSD_AM_IO
		&& acc_addr >= 16'h0040 |=> acc_err) else $error("io index above 63 accepted");
	a_disp_x_err: assert property (take && acc_mode == DSD_AM_DISP
		&& acc_ptr == 2'h0 |=> acc_err) else $error("displacement on x accepted");
	a_read_stall: assert property (take && acc_we && acc_mode == DSD_AM_IO
		&& acc_addr == 16'(DSD_IO_NVM_CTRL) && acc_wdata == 8'h01 && !nvm_busy
		|=> cpu_stall [*4] ##1 !cpu_stall) else $error("read stall not four cycles");
	a_write_stall: assert property ($rose(nvm_busy)
		|-> cpu_stall [*2] ##1 !cpu_stall) else $error("write stall not two cycles");
	a_busy_length: assert property ($fell(nvm_busy) |-> busy_cnt_r == 16'(ATOMIC_CYC)
		|| busy_cnt_r == 16'(SPLIT_CYC)) else $error("programming time wrong");
	a_prog_addr_pc: assert property (prog_addr == 16'(pc))
		else $error("program address differs from counter");
endmodule

bind dsd_memsys dsd_memsys_chk #(.SRAM_BYTES(SRAM_BYTES), .PROG_WORDS(PROG_WORDS),
	.ATOMIC_CYC(ATOMIC_CYC), .SPLIT_CYC(SPLIT_CYC)) u_chk (.clk(clk), .nrst(nrst),
	.acc_req(acc_req), .acc_we(acc_we), .acc_mode(acc_mode), .acc_addr(acc_addr),
	.acc_ptr(acc_ptr), .acc_wdata(acc_wdata), .acc_done(acc_done), .acc_err(acc_err),
	.cpu_stall(cpu_stall), .pc(pc), .prog_addr(prog_addr), .nvm_busy(nvm_busy));

//--- tb/testbench.sv
// Self-checking bench of the memory subsystem
`define CHK(nm, ex, got) begin comparisons++; if ((got) !== (ex)) begin errors++; \
	$display("CHECK FAILED %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	import dsd_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic acc_req = 1'b0;
	logic acc_we = 1'b0;
	dsd_amode_t acc_mode = DSD_AM_DIRECT;
	logic [15:0] acc_addr = 16'h0000;
	logic [1:0] acc_ptr = 2'h0;
	logic [5:0] acc_disp = 6'h00;
	logic [7:0] acc_wdata = 8'h00;
	logic [12:0] pc_next = 13'h0000;
	logic pc_load = 1'b0;
	logic [7:0] acc_rdata;
	logic acc_done, acc_err, cpu_stall, nvm_busy;
	logic [12:0] pc;
	logic [15:0] prog_addr, prog_word, instr_r;
	logic [7:0] rd;
	logic got_err;
	int errors = 0;
	int comparisons = 0;
	always #50 clk = ~clk;
	dsd_memsys #(.ATOMIC_CYC(20), .SPLIT_CYC(10)) i_dsd_memsys (.clk(clk), .nrst(nrst),
		.acc_req(acc_req), .acc_we(acc_we), .acc_mode(acc_mode), .acc_addr(acc_addr),
		.acc_ptr(acc_ptr), .acc_disp(acc_disp), .acc_wdata(acc_wdata),
		.acc_rdata(acc_rdata), .acc_done(acc_done), .acc_err(acc_err),
		.cpu_stall(cpu_stall), .pc_next(pc_next), .pc_load(pc_load), .pc(pc),
		.prog_addr(prog_addr), .prog_word(prog_word), .instr_r(instr_r),
		.nvm_busy(nvm_busy));
	dsd_prog_rom i_dsd_prog_rom (.prog_addr(prog_addr), .prog_word(prog_word));
	// ==========================================================
	// Tasks
	task automatic complete_run();
		$display("comparisons %0d errors %0d", comparisons, errors);
		if (errors == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic acc(input logic we, input dsd_amode_t md, input logic [15:0] ad,
		input logic [7:0] wd, input logic [1:0] pt = 2'h0, input logic [5:0] dp = 6'h00);
		int n;
		n = 0;
		@(negedge clk);
		while (cpu_stall !== 1'b0 && n < 50) begin
			@(negedge clk);
			n++;
		end
		acc_req = 1'b1;
		acc_we = we;
		acc_mode = md;
		acc_addr = ad;
		acc_wdata = wd;
		acc_ptr = pt;
		acc_disp = dp;
		@(negedge clk);
		acc_req = 1'b0;
		while (acc_done !== 1'b1 && acc_err !== 1'b1 && n < 50) begin
			@(negedge clk);
			n++;
		end
		if (n >= 50) begin
			errors++;
			complete_run();
		end
		rd = acc_rdata;
		got_err = acc_err;
	endtask
	task automatic rd_chk(input dsd_amode_t md, input logic [15:0] ad, input logic [7:0] ex);
		acc(1'b0, md, ad, 8'h00);
		`CHK("load data", ex, rd)
	endtask
	task automatic t_regions();
		// Standard I/O holds only the port registers, so the probes use data and pointer
		logic [15:0] adr [7] = '{16'h001F, 16'h0040, 16'h0041, 16'h0060, 16'h00FF,
			16'h0100, 16'h04FF};
		foreach (adr[i]) acc(1'b1, DSD_AM_DIRECT, adr[i], 8'(i) ^ 8'hC3);
		foreach (adr[i]) rd_chk(DSD_AM_DIRECT, adr[i], 8'(i) ^ 8'hC3);
		acc(1'b0, DSD_AM_DIRECT, 16'h0500, 8'h00);
		`CHK("unmapped refused", 1'b1, got_err)
		acc(1'b1, DSD_AM_IO, 16'h0020, 8'h77);
		rd_chk(DSD_AM_DIRECT, 16'h0040, 8'h77);
		acc(1'b0, DSD_AM_IO, 16'h0040, 8'h00);
		`CHK("io index refused", 1'b1, got_err)
	endtask
	task automatic t_ptr();
		acc(1'b1, DSD_AM_DIRECT, 16'h001A, 8'h20);
		acc(1'b1, DSD_AM_DIRECT, 16'h001B, 8'h01);
		acc(1'b1, DSD_AM_POSTINC, 16'h0000, 8'h11, 2'h0);
		rd_chk(DSD_AM_DIRECT, 16'h001A, 8'h21);
		acc(1'b1, DSD_AM_PREDEC, 16'h0000, 8'h22, 2'h0);
		rd_chk(DSD_AM_IND, 16'h0000, 8'h22);
		acc(1'b1, DSD_AM_DIRECT, 16'h001E, 8'hFF);
		acc(1'b1, DSD_AM_DIRECT, 16'h001F, 8'h00);
		acc(1'b1, DSD_AM_DISP, 16'h0000, 8'h5E, 2'h2, 6'h3F);
		rd_chk(DSD_AM_DIRECT, 16'h013E, 8'h5E);
		acc(1'b0, DSD_AM_DISP, 16'h0000, 8'h00, 2'h0, 6'h01);
		`CHK("disp on x refused", 1'b1, got_err)
	endtask
	task automatic nvm_prog(input logic [1:0] md, input logic [7:0] dat, input logic [7:0] ex);
		int n;
		n = 0;
		acc(1'b1, DSD_AM_IO, 16'h0020, dat);
		acc(1'b1, DSD_AM_IO, 16'h001F, {2'h0, md, 4'h4});
		acc(1'b1, DSD_AM_IO, 16'h001F, {2'h0, md, 4'h2});
		`CHK("busy after strobe", 1'b1, nvm_busy)
		acc(1'b1, DSD_AM_IO, 16'h0021, 8'h00);
		acc(1'b0, DSD_AM_IO, 16'h001F, 8'h00);
		`CHK("strobe polled", 1'b1, rd[1])
		while (nvm_busy !== 1'b0 && n < 40) begin
			@(negedge clk);
			n++;
		end
		if (n >= 40) begin
			errors++;
			complete_run();
		end
		acc(1'b0, DSD_AM_IO, 16'h001F, 8'h00);
		`CHK("strobe cleared", 1'b0, rd[1])
		rd_chk(DSD_AM_IO, 16'h0021, 8'h34);
		// Clear the data register so only the array can supply the expected byte
		acc(1'b1, DSD_AM_IO, 16'h0020, 8'h00);
		acc(1'b1, DSD_AM_IO, 16'h001F, 8'h01);
		rd_chk(DSD_AM_IO, 16'h0020, ex);
	endtask
	task automatic t_nvm();
		acc(1'b1, DSD_AM_IO, 16'h0022, 8'hFF);
		rd_chk(DSD_AM_IO, 16'h0022, 8'h01);
		acc(1'b1, DSD_AM_IO, 16'h0021, 8'h34);
		acc(1'b1, DSD_AM_IO, 16'h001F, 8'h02);
		`CHK("strobe without arm", 1'b0, nvm_busy)
		nvm_prog(2'h0, 8'h5A, 8'h5A);
		nvm_prog(2'h1, 8'h00, 8'hFF);
		nvm_prog(2'h2, 8'h0F, 8'h0F);
		acc(1'b1, DSD_AM_IO, 16'h001F, 8'h34);
		acc(1'b1, DSD_AM_IO, 16'h001F, 8'h32);
		`CHK("reserved mode idle", 1'b0, nvm_busy)
	endtask
	task automatic t_pc();
		@(negedge clk);
		pc_next = 13'h1ABC;
		pc_load = 1'b1;
		@(negedge clk);
		pc_load = 1'b0;
		`CHK("program counter", 13'h1ABC, pc)
		`CHK("program address", 16'h1ABC, prog_addr)
		// Program model returns the address mixed with its fixed pattern
		repeat (2) @(negedge clk);
		`CHK("instruction word", 16'hBF7F, instr_r)
	endtask
	// ==========================================================
	// Main sequence
	initial begin
		repeat (5) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		repeat (3) @(posedge clk);
		t_regions();
		t_ptr();
		t_nvm();
		t_pc();
		complete_run();
	end
endmodule
